// File: core/dts_defines.svh
`ifndef DTS_DEFINES_SVH
`define DTS_DEFINES_SVH

// ----------------------------------------------------------------
// Mode register field positions
// ----------------------------------------------------------------
`define DTS_MR_W 16
`define DTS_MR1_NOM_B2 9
`define DTS_MR1_NOM_B1 6
`define DTS_MR1_NOM_B0 2
`define DTS_MR1_AL_HI 4
`define DTS_MR1_AL_LO 3
`define DTS_MR2_WR_HI 10
`define DTS_MR2_WR_LO 9
`define DTS_MR2_CWL_HI 5
`define DTS_MR2_CWL_LO 3

// ----------------------------------------------------------------
// Strength codes
// ----------------------------------------------------------------
`define DTS_NOM_OFF 3'h0
`define DTS_NOM_RZQ4 3'h1
`define DTS_NOM_RZQ2 3'h2
`define DTS_NOM_RZQ6 3'h3
`define DTS_NOM_RZQ12 3'h4
`define DTS_NOM_RZQ8 3'h5
`define DTS_NOM_RSVD_A 3'h6
`define DTS_NOM_RSVD_B 3'h7
`define DTS_WR_OFF 2'h0
`define DTS_WR_RSVD 2'h3

// ----------------------------------------------------------------
// Latencies in link clocks
// ----------------------------------------------------------------
`define DTS_CWL_BASE 5'h05
`define DTS_CL 5'h06
`define DTS_AL_CODE_ZERO 2'h0
`define DTS_AL_CODE_M1 2'h1
`define DTS_AL_CODE_M2 2'h2
`define DTS_LAT_OFS 5'h02
`define DTS_ONE 5'h01
`define DTS_CHOP_EXTRA 3'h4
`define DTS_FULL_EXTRA 3'h6
`define DTS_HOLD_CHOP 3'h4
`define DTS_HOLD_FULL 3'h6
`define DTS_HIST_W 32

// ----------------------------------------------------------------
// Controller register map
// ----------------------------------------------------------------
`define DTS_REG_MR1 8'h00
`define DTS_REG_MR2 8'h04
`define DTS_REG_WR 8'h08
`define DTS_REG_ODT 8'h0C
`define DTS_REG_CFG 8'h10
`define DTS_REG_STAT 8'h14
`define DTS_ST_PEND 0
`define DTS_ST_ERR 1
`define DTS_ST_ODT 2
`define DTS_ST_HOLD 3

`endif

// File: core/dts_pkg.sv
`include "dts_defines.svh"

package dts_pkg;
	typedef logic [`DTS_MR_W-1:0] dts_mr_t;
	typedef logic [2:0] dts_nom_t;
	typedef logic [1:0] dts_wr_t;
	typedef logic [4:0] dts_lat_t;

	function automatic dts_nom_t dts_nom_code(input dts_mr_t mr);
		return {mr[`DTS_MR1_NOM_B2], mr[`DTS_MR1_NOM_B1],
			mr[`DTS_MR1_NOM_B0]};
	endfunction

	function automatic dts_wr_t dts_wr_code(input dts_mr_t mr);
		return mr[`DTS_MR2_WR_HI:`DTS_MR2_WR_LO];
	endfunction
endpackage

// File: core/dts_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface dts_link_if;
	logic ck;
	logic odt;
	logic mrs_valid;
	logic mrs_sel_two;
	logic [15:0] mrs_data;
	logic wr_valid;
	logic wr_chop;

	modport ctrl(output ck, output odt, output mrs_valid,
		output mrs_sel_two, output mrs_data, output wr_valid,
		output wr_chop);
	modport dev(input ck, input odt, input mrs_valid,
		input mrs_sel_two, input mrs_data, input wr_valid,
		input wr_chop);
endinterface

`default_nettype wire

// File: core/dts_device.sv
// How it works
// - Either write-strength bit set enables dynamic switching.
// - Controller forces write strength off on register two writes made while DLL off.
// - Nominal strength from register one bits 9,6,2.
// - Write strength from register two bits 10,9.
// - Write code zero leaves nominal strength untouched.
// - Idle termination uses nominal strength only.
// - Outside writes, pin level delayed gives on/off.
// - Every write form triggers strength switching.
// - Switch to write strength at latency minus two.
// - Back to nominal after off latency plus 4/6.
// - During writes pin and latencies still govern on/off.
// - Strength undefined briefly after the switch.
// - Controller refuses writes with pin high when write strength is off and the nominal code is unsafe.
// - Ordinary latencies unchanged with dynamic switching.
// - On/off latency is write latency minus two.
// - Pin high four clocks after rise or chop.
// - Pin held high six clocks after full write.
`include "dts_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module dts_device (
	dts_link_if.dev link, // link from the controller, clocked by link.ck
	input wire logic rst, // asynchronous reset, active high
	output logic rtt_on, // termination applied
	output logic rtt_is_write, // write strength selected
	output logic [2:0] rtt_code, // selected strength code
	output logic rtt_skew, // strength undefined this clock
	output logic dyn_enabled, // dynamic switching enabled
	output logic cfg_illegal // a reserved code is programmed
);
	import dts_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		dts_nom_t nom;
		dts_wr_t wr;
		logic [2:0] cwl_code;
		logic [1:0] al_code;
		logic [`DTS_HIST_W-1:0] odt_sh;
		logic [`DTS_HIST_W-1:0] wr_sh;
		logic [`DTS_HIST_W-1:0] chop_sh;
		logic [2:0] wcnt;
		logic on;
		logic is_write;
		logic [2:0] code;
		logic skew;
		logic dyn;
		logic illegal;
	} dts_dev_state_t;

	dts_dev_state_t state_ff;
	dts_dev_state_t nxt_state;
	dts_lat_t al;
	dts_lat_t lat;
	dts_lat_t idx;
	logic dyn_en;
	logic odt_late;
	logic wr_late;
	logic chop_late;

	// ----------------------------------------------------------------
	// Latency decode
	// ----------------------------------------------------------------
	always_comb begin
		case (state_ff.al_code)
			`DTS_AL_CODE_M1: al = `DTS_CL - `DTS_ONE;
			`DTS_AL_CODE_M2: al = `DTS_CL - `DTS_LAT_OFS;
			default: al = 5'h00;
		endcase
		lat = `DTS_CWL_BASE + {2'h0, state_ff.cwl_code} + al
			- `DTS_LAT_OFS;
		// The sample taken at edge k sits in bit j after edge k+j.
		idx = lat - `DTS_ONE;
	end

	assign dyn_en = (state_ff.wr != `DTS_WR_OFF);

	assign odt_late = state_ff.odt_sh[idx];
	// Write seen after WL minus two
	assign wr_late = state_ff.wr_sh[idx];
	assign chop_late = state_ff.chop_sh[idx];

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;

		// Mode register loads.
		if (link.mrs_valid) begin
			if (link.mrs_sel_two) begin
				nxt_state.wr = dts_wr_code(link.mrs_data);
				nxt_state.cwl_code =
					link.mrs_data[`DTS_MR2_CWL_HI:`DTS_MR2_CWL_LO];
			end else begin
				nxt_state.nom = dts_nom_code(link.mrs_data);
				nxt_state.al_code =
					link.mrs_data[`DTS_MR1_AL_HI:`DTS_MR1_AL_LO];
			end
		end

		nxt_state.odt_sh = {state_ff.odt_sh[`DTS_HIST_W-2:0], link.odt};
		// Any write form with dynamic enabled
		nxt_state.wr_sh = {state_ff.wr_sh[`DTS_HIST_W-2:0],
			link.wr_valid & dyn_en};
		nxt_state.chop_sh = {state_ff.chop_sh[`DTS_HIST_W-2:0],
			link.wr_chop};

		if (wr_late) begin
			nxt_state.wcnt = chop_late ? `DTS_CHOP_EXTRA
				: `DTS_FULL_EXTRA;
		end else if (state_ff.wcnt != 3'h0) begin
			nxt_state.wcnt = state_ff.wcnt - 3'h1;
		end

		// Code zero never marks a write
		nxt_state.is_write = (nxt_state.wcnt != 3'h0);

		// Pin gates termination in writes too
		nxt_state.on = odt_late &
			((state_ff.nom != `DTS_NOM_OFF) | nxt_state.is_write);

		if (nxt_state.is_write) begin
			nxt_state.code = {1'b0, state_ff.wr};
		end else begin
			nxt_state.code = state_ff.nom;
		end

		nxt_state.skew = wr_late & (state_ff.wcnt == 3'h0);

		nxt_state.dyn = dyn_en;
		nxt_state.illegal = (state_ff.wr == `DTS_WR_RSVD) |
			(state_ff.nom == `DTS_NOM_RSVD_A) |
			(state_ff.nom == `DTS_NOM_RSVD_B);
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge link.ck or posedge rst) begin
		if (rst) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign rtt_on = state_ff.on;
	assign rtt_is_write = state_ff.is_write;
	assign rtt_code = state_ff.code;
	assign rtt_skew = state_ff.skew;
	assign dyn_enabled = state_ff.dyn;
	assign cfg_illegal = state_ff.illegal;

endmodule // dts_device

`default_nettype wire

// File: core/dts_controller.sv
`include "dts_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module dts_controller (
	input wire logic clock, // system clock
	input wire logic rst, // asynchronous reset, active high
	input wire logic [7:0] addr, // register address
	input wire logic [31:0] wdata, // write data
	input wire logic wr, // write strobe
	input wire logic rd, // read strobe
	output logic [31:0] rdata, // read data, cycle after rd
	dts_link_if.ctrl link // link to the device
);
	import dts_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic ck;
		dts_mr_t mr1;
		dts_mr_t mr2;
		logic dll_off;
		logic pend_mr1;
		logic pend_mr2;
		logic pend_wr;
		logic pend_chop;
		logic odt_req;
		logic [2:0] hold;
		logic err;
		logic [31:0] rdata;
		logic odt;
		logic mrs_valid;
		logic mrs_sel_two;
		dts_mr_t mrs_data;
		logic wr_valid;
		logic wr_chop;
	} dts_ctl_state_t;

	dts_ctl_state_t state_ff;
	dts_ctl_state_t nxt_state;
	logic pend;
	logic launch;
	logic odt_now;
	logic bad_nom;

	assign pend = state_ff.pend_mr1 | state_ff.pend_mr2 | state_ff.pend_wr;
	// Link signals change on the same clock edge as the falling link clock edge.
	assign launch = state_ff.ck;
	// Hold the pin high while the count runs
	assign odt_now = state_ff.odt_req | (state_ff.hold != 3'h0);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		nxt_state.ck = ~state_ff.ck;
		nxt_state.rdata = 32'h0000_0000;
		// Nominal code unsafe for write use
		bad_nom = (state_ff.mr2[`DTS_MR2_WR_HI:`DTS_MR2_WR_LO]
			== `DTS_WR_OFF) &
			((dts_nom_code(state_ff.mr1) == `DTS_NOM_RZQ12) |
			(dts_nom_code(state_ff.mr1) == `DTS_NOM_RZQ8));

		if (rd) begin
			if (addr == `DTS_REG_MR1) begin
				nxt_state.rdata = {16'h0000, state_ff.mr1};
			end else if (addr == `DTS_REG_MR2) begin
				nxt_state.rdata = {16'h0000, state_ff.mr2};
			end else if (addr == `DTS_REG_ODT) begin
				nxt_state.rdata = {31'h0, state_ff.odt_req};
			end else if (addr == `DTS_REG_CFG) begin
				nxt_state.rdata = {31'h0, state_ff.dll_off};
			end else if (addr == `DTS_REG_STAT) begin
				nxt_state.rdata = {28'h0, state_ff.hold != 3'h0,
					state_ff.odt, state_ff.err, pend};
			end
		end

		// Link launch: one pending command per link clock.
		if (launch) begin
			nxt_state.mrs_valid = 1'b0;
			nxt_state.wr_valid = 1'b0;
			nxt_state.odt = odt_now;
			nxt_state.hold = (state_ff.hold != 3'h0)
				? state_ff.hold - 3'h1 : 3'h0;
			if (odt_now & ~state_ff.odt) begin
				nxt_state.hold = `DTS_HOLD_CHOP - 3'h1;
			end
			if (state_ff.pend_mr1) begin
				nxt_state.pend_mr1 = 1'b0;
				nxt_state.mrs_valid = 1'b1;
				nxt_state.mrs_sel_two = 1'b0;
				nxt_state.mrs_data = state_ff.mr1;
			end else if (state_ff.pend_mr2) begin
				nxt_state.pend_mr2 = 1'b0;
				nxt_state.mrs_valid = 1'b1;
				nxt_state.mrs_sel_two = 1'b1;
				nxt_state.mrs_data = state_ff.mr2;
			end else if (state_ff.pend_wr) begin
				nxt_state.pend_wr = 1'b0;
				nxt_state.wr_valid = 1'b1;
				nxt_state.wr_chop = state_ff.pend_chop;
				if (odt_now & state_ff.pend_chop) begin
					if (nxt_state.hold < `DTS_HOLD_CHOP - 3'h1) begin
						nxt_state.hold = `DTS_HOLD_CHOP - 3'h1;
					end
				end else if (odt_now) begin
					nxt_state.hold = `DTS_HOLD_FULL - 3'h1;
				end
			end
		end

		if (wr) begin
			if (addr == `DTS_REG_MR1) begin
				if (state_ff.pend_mr1 |
					(dts_nom_code(wdata[15:0]) == `DTS_NOM_RSVD_A) |
					(dts_nom_code(wdata[15:0]) == `DTS_NOM_RSVD_B)) begin
					nxt_state.err = 1'b1;
				end else begin
					nxt_state.mr1 = wdata[15:0];
					nxt_state.pend_mr1 = 1'b1;
				end
			end else if (addr == `DTS_REG_MR2) begin
				if (state_ff.pend_mr2 |
					(dts_wr_code(wdata[15:0]) == `DTS_WR_RSVD)) begin
					nxt_state.err = 1'b1;
				end else begin
					nxt_state.mr2 = wdata[15:0];
					// Write strength off with DLL off
					if (state_ff.dll_off) begin
						nxt_state.mr2[`DTS_MR2_WR_HI:`DTS_MR2_WR_LO] =
							`DTS_WR_OFF;
					end
					nxt_state.pend_mr2 = 1'b1;
				end
			end else if (addr == `DTS_REG_WR) begin
				if (state_ff.pend_wr | (bad_nom & odt_now)) begin
					nxt_state.err = 1'b1;
				end else begin
					nxt_state.pend_wr = 1'b1;
					nxt_state.pend_chop = wdata[0];
				end
			end else if (addr == `DTS_REG_ODT) begin
				nxt_state.odt_req = wdata[0];
			end else if (addr == `DTS_REG_CFG) begin
				nxt_state.dll_off = wdata[0];
			end else if (addr == `DTS_REG_STAT) begin
				// Writing a one to the error bit clears the flag.
				if (wdata[`DTS_ST_ERR] & ~nxt_state.err) begin
					nxt_state.err = 1'b0;
				end else if (wdata[`DTS_ST_ERR] & state_ff.err) begin
					nxt_state.err = 1'b0;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign rdata = state_ff.rdata;
	assign link.ck = state_ff.ck;
	assign link.odt = state_ff.odt;
	assign link.mrs_valid = state_ff.mrs_valid;
	assign link.mrs_sel_two = state_ff.mrs_sel_two;
	assign link.mrs_data = state_ff.mrs_data;
	assign link.wr_valid = state_ff.wr_valid;
	assign link.wr_chop = state_ff.wr_chop;

endmodule // dts_controller

`default_nettype wire

// File: tb/dts_chk.sv
`timescale 1ns/1ps
`default_nettype none

module dts_chk (
	input wire logic ck, // link clock
	input wire logic rst, // reset
	input wire logic odt, // pin
	input wire logic mrs_valid, // load
	input wire logic mrs_sel_two, // reg two
	input wire logic [15:0] mrs_data, // value
	input wire logic wr_valid, // write
	input wire logic wr_chop, // chop
	input wire logic rtt_on, // applied
	input wire logic rtt_is_write, // write str
	input wire logic [2:0] rtt_code, // code
	input wire logic rtt_skew, // skew
	input wire logic dyn_enabled // dynamic on
);
	// ----------------------------------------------------------------
	// Shadow fields; latency 3 needs CWL 5 and AL 0.
	// Sampled outputs show an edge's update one clock later.
	// ----------------------------------------------------------------
	logic [2:0] nom_ff;
	logic [1:0] wcode_ff;

	always_ff @(posedge ck or posedge rst) begin
		if (rst) begin
			nom_ff <= 3'h0;
			wcode_ff <= 2'h0;
		end else if (mrs_valid && mrs_sel_two) begin
			wcode_ff <= mrs_data[10:9];
		end else if (mrs_valid) begin
			nom_ff <= {mrs_data[9], mrs_data[6], mrs_data[2]};
		end
	end

	default clocking cb @(posedge ck); endclocking
	default disable iff (rst);

	a_dyn_enable: assert property (
		!mrs_valid && !$past(mrs_valid) |-> dyn_enabled == (wcode_ff != 2'h0))
		else $error("dynamic enable wrong");
	a_nom_code: assert property (
		!rtt_is_write && !mrs_valid && !$past(mrs_valid) |-> rtt_code == nom_ff)
		else $error("nominal code wrong");
	a_wr_code: assert property (
		rtt_is_write |-> rtt_code == {1'b0, wcode_ff})
		else $error("write code wrong");
	a_on_latency: assert property (
		!rtt_is_write && !$past(mrs_valid) |->
		rtt_on == ($past(odt, 4) && nom_ff != 3'h0))
		else $error("termination on wrong");
	a_switch_full: assert property (
		wr_valid && !wr_chop && wcode_ff != 2'h0 |->
		##4 rtt_is_write [*6] ##1 !rtt_is_write)
		else $error("full write span wrong");
	a_switch_chop: assert property (
		wr_valid && wr_chop && wcode_ff != 2'h0 |->
		##4 rtt_is_write [*4] ##1 !rtt_is_write)
		else $error("chop write span wrong");
	a_no_switch: assert property (
		wr_valid && wcode_ff == 2'h0 |-> ##4 !rtt_is_write)
		else $error("switch with code off");
	a_skew_pulse: assert property (
		rtt_skew |-> $rose(rtt_is_write) ##1 !rtt_skew)
		else $error("skew pulse wrong");
	a_rise_hold: assert property (
		$rose(odt) |-> odt [*4])
		else $error("pin low too soon");
	a_write_hold: assert property (
		wr_valid && odt |-> odt [*4] ##1
		($past(wr_chop, 4) || odt [*2]))
		else $error("pin low after write");
	a_one_cmd: assert property (
		!(mrs_valid && wr_valid))
		else $error("two commands at once");
endmodule // dts_chk

`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic clock = 1'b0;
	logic rst;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic rtt_on, rtt_is_write, rtt_skew, dyn_enabled, cfg_illegal;
	logic [2:0] rtt_code;
	int errors = 0;
	int num_checks = 0;
	int n;

	always #10 clock = ~clock;

	dts_link_if link();
	dts_controller u_dts_controller(.clock(clock), .rst(rst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .link(link));
	dts_device u_dts_device(.link(link), .rst(rst), .rtt_on(rtt_on),
		.rtt_is_write(rtt_is_write), .rtt_code(rtt_code),
		.rtt_skew(rtt_skew), .dyn_enabled(dyn_enabled),
		.cfg_illegal(cfg_illegal));
	dts_chk u_dts_chk(.ck(link.ck), .rst(rst), .odt(link.odt),
		.mrs_valid(link.mrs_valid), .mrs_sel_two(link.mrs_sel_two),
		.mrs_data(link.mrs_data), .wr_valid(link.wr_valid),
		.wr_chop(link.wr_chop), .rtt_on(rtt_on),
		.rtt_is_write(rtt_is_write), .rtt_code(rtt_code),
		.rtt_skew(rtt_skew), .dyn_enabled(dyn_enabled));

	task automatic close_out;
		if (errors == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", what, exp, got);
			errors++;
		end
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask

	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	task automatic reg_chk(input string what, input logic [7:0] a,
		input logic [31:0] exp);
		logic [31:0] d;
		reg_rd(a, d);
		chk(what, exp, d);
	endtask

	// Waits for the link load to finish and the latencies to run out.
	task automatic settle;
		logic [31:0] d;
		d = 32'h1;
		for (int i = 0; i < 40 && d[0] !== 1'b0; i++) reg_rd(8'h14, d);
		repeat (30) @(posedge clock);
		#1;
	endtask

	task automatic burst(input logic chop, input logic [2:0] code,
		input int len);
		reg_wr(8'h08, {31'h0, chop});
		n = 0;
		for (int i = 0; i < 40 && rtt_is_write !== 1'b1; i++) begin
			@(posedge link.ck);
			#1;
		end
		while (rtt_is_write === 1'b1 && n < 20) begin
			chk("rtt_code", {29'h0, code}, {29'h0, rtt_code});
			@(posedge link.ck);
			#1;
			n++;
		end
		chk("write span", len, n);
		settle;
	endtask

	initial begin
		repeat (20000) @(posedge clock);
		errors++;
		close_out;
	end

	initial begin
		// A real rising edge on reset clears both ends asynchronously.
		rst <= 1'b1;
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		#1;
		chk("rtt_on", 32'h0, {31'h0, rtt_on});
		reg_chk("unmapped", 8'h20, 32'h0);
		reg_wr(8'h00, 32'h0000_0040);
		settle;
		reg_wr(8'h04, 32'h0000_0200);
		settle;
		reg_chk("mr1", 8'h00, 32'h0000_0040);
		chk("dyn_enabled", 32'h1, {31'h0, dyn_enabled});
		reg_wr(8'h0C, 32'h1);
		settle;
		chk("rtt_on", 32'h1, {31'h0, rtt_on});
		chk("rtt_code", 32'h2, {29'h0, rtt_code});
		reg_chk("stat", 8'h14, 32'h4);
		burst(1'b1, 3'h1, 4);
		burst(1'b0, 3'h1, 6);
		reg_wr(8'h04, 32'h0000_0400);
		settle;
		burst(1'b0, 3'h2, 6);
		reg_wr(8'h00, 32'h0000_0240);
		settle;
		reg_chk("nom reserved", 8'h14, 32'h6);
		reg_wr(8'h14, 32'h2);
		reg_wr(8'h04, 32'h0000_0600);
		settle;
		reg_chk("wr reserved", 8'h14, 32'h6);
		reg_wr(8'h14, 32'h2);
		chk("cfg_illegal", 32'h0, {31'h0, cfg_illegal});
		reg_wr(8'h04, 32'h0);
		reg_wr(8'h00, 32'h0000_0200);
		settle;
		burst(1'b0, 3'h0, 0);
		reg_chk("nom refused", 8'h14, 32'h6);
		reg_wr(8'h14, 32'h2);
		reg_wr(8'h00, 32'h0000_0040);
		settle;
		burst(1'b0, 3'h0, 0);
		chk("rtt_code", 32'h2, {29'h0, rtt_code});
		reg_wr(8'h10, 32'h1);
		reg_wr(8'h04, 32'h0000_0200);
		settle;
		chk("dyn_enabled", 32'h0, {31'h0, dyn_enabled});
		reg_wr(8'h0C, 32'h0);
		settle;
		chk("rtt_on", 32'h0, {31'h0, rtt_on});
		close_out;
	end
endmodule // tb

`default_nettype wire
